/* File: dcgp_cmd_front.sv */
// Command input front end: gear-down, maximum power saving and parity check.
`default_nettype none
module dcgp_cmd_front
    import dcgp_pkg::*;
#(
    parameter int GEAR_CMD_DLY = GEAR_CMD_CYC,
    parameter int MPED_CYC     = MPED_CYC_DEF,
    parameter int XMP_CYC      = XMP_CYC_DEF,
    parameter int ALERT_PW_CYC = ALERT_PW_CYC_DEF,
    parameter int TRAS_CYC     = TRAS_CYC_DEF,
    parameter bit USE_A17      = 1'b1
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_cs_n,
    input  wire logic                       i_cke,
    input  wire logic                       i_act_n,
    input  wire logic                       i_ras_n,
    input  wire logic                       i_cas_n,
    input  wire logic                       i_we_n,
    input  wire logic                       i_a17,
    input  wire logic [1:0]                 i_bg,
    input  wire logic [1:0]                 i_ba,
    input  wire logic [dcgp_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                       i_par,
    input  wire logic                       i_self_refresh,
    output logic                            o_cmd_vld,
    output logic [dcgp_pkg::CMD_W-1:0]      o_cmd_word,
    output logic                            o_gear_2n,
    output logic                            o_mps_active,
    output logic                            o_mr4_mps,
    output logic [2:0]                      o_parity_delay,
    output logic                            o_par_status,
    output logic [31:0]                     o_err_log,
    output logic                            o_pre_all,
    output logic                            o_alert_n
);
    import dcgp_pkg::*;

    localparam int ALERT_END = (ALERT_PW_CYC > TRAS_CYC) ? ALERT_PW_CYC : TRAS_CYC + 1;
    localparam logic [CNT_W-1:0] GEAR_N  = CNT_W'(GEAR_CMD_DLY);
    localparam logic [CNT_W-1:0] MPED_N  = CNT_W'(MPED_CYC);
    localparam logic [CNT_W-1:0] XMP_N   = CNT_W'(XMP_CYC);
    localparam logic [CNT_W-1:0] TRAS_N  = CNT_W'(TRAS_CYC - 1);
    localparam logic [CNT_W-1:0] AEND_N  = CNT_W'(ALERT_END - 1);
    // Reset makes the pins look idle with CKE high, so no false CKE rise follows reset.
    localparam logic [PIN_W-1:0] PIN_RST = {1'b0, 1'b1, {P_CKE{1'b0}}};

    if (GEAR_CMD_DLY < 1 || MPED_CYC < 1 || XMP_CYC < 1 || TRAS_CYC < 1 ||
        ALERT_PW_CYC < 1 || ALERT_END >= (1 << CNT_W)) begin : g_bad_param
        $error("dcgp_cmd_front: timing count out of range");
    end

    function automatic logic is_mrs(input logic [CMD_W-1:0] w, input logic [2:0] sel);
        is_mrs = w[C_ACT] & ~w[C_RAS] & ~w[C_CAS] & ~w[C_WE] &
                 ({w[C_BG0], w[C_BA1], w[C_BA0]} == sel);
    endfunction : is_mrs

    function automatic logic [3:0] pl_clocks(input logic [2:0] code);
        unique case (code)
            PL_C4:   pl_clocks = PL_N4;
            PL_C5:   pl_clocks = PL_N5;
            PL_C6:   pl_clocks = PL_N6;
            PL_C8:   pl_clocks = PL_N8;
            default: pl_clocks = 4'h0;
        endcase
    endfunction : pl_clocks

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read.
    logic [PIN_W-1:0]  pin_s1_ff;
    logic [PIN_W-1:0]  pin_s2_ff;
    logic              cke_d_ff;
    logic              cs_d_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pin_s1_ff <= PIN_RST;
            pin_s2_ff <= PIN_RST;
            cke_d_ff  <= 1'b1;
            cs_d_ff   <= 1'b0;
        end else begin
            pin_s1_ff <= {~i_cs_n, i_cke, i_par, i_act_n, i_ras_n, i_cas_n, i_we_n,
                          i_bg, i_ba, i_a17, i_addr};
            pin_s2_ff <= pin_s1_ff;
            cke_d_ff  <= pin_s2_ff[P_CKE];
            cs_d_ff   <= pin_s2_ff[P_CS];
        end
    end

    logic              cs_q;
    logic              cke_rise;
    logic [CMD_W-1:0]  cw;
    logic              par_bad;
    logic              checking;
    logic              slot_ok;
    logic              take;
    logic              err_evt;
    logic              exe;
    logic [2:0]        pl_ff;
    logic              status_ff;
    logic              gear_2n_ff;
    logic              phase_ff;
    logic              abusy_ff;
    dcgp_mps_e         mps_st;

    assign cs_q     = pin_s2_ff[P_CS];
    assign cke_rise = pin_s2_ff[P_CKE] & ~cke_d_ff;
    assign cw       = {pin_s2_ff[P_CMD_HI -: 8], pin_s2_ff[C_A17] & USE_A17,
                       pin_s2_ff[ADDR_W-1:0]};
    assign par_bad  = ^{cw, pin_s2_ff[P_PAR]};
    assign checking = (pl_ff != PL_OFF) && !status_ff;
    assign slot_ok  = !gear_2n_ff || !phase_ff;
    assign take     = cs_q && slot_ok && (mps_st == DCGP_MPS_OFF) && !abusy_ff;
    assign err_evt  = take && checking && par_bad;
    assign exe      = take && !err_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Gear-down control.
    logic              garm_ff;
    logic [CNT_W-1:0]  gcnt_ff;
    logic [CNT_W-1:0]  gdly_ff;
    logic              sync_hit;

    assign sync_hit = garm_ff && cs_q && !cs_d_ff && !gcnt_ff[0] && (gcnt_ff >= CNT_TWO);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            garm_ff    <= 1'b0;
            gcnt_ff    <= CNT_ZERO;
            gdly_ff    <= CNT_ZERO;
            gear_2n_ff <= 1'b0;
            phase_ff   <= 1'b0;
        end else if (i_self_refresh || mps_st != DCGP_MPS_OFF) begin
            garm_ff    <= 1'b0;
            gdly_ff    <= CNT_ZERO;
            gear_2n_ff <= 1'b0;
            phase_ff   <= 1'b0;
        end else begin
            phase_ff <= ~phase_ff;
            if (exe && is_mrs(cw, MR3_SEL)) begin
                garm_ff <= cw[GEAR_BIT];
                // Start at one so the count equals clocks since the write at the sync.
                gcnt_ff <= CNT_ONE;
                if (!cw[GEAR_BIT]) begin
                    gear_2n_ff <= 1'b0;
                end
            end else if (sync_hit) begin
                garm_ff <= 1'b0;
                gdly_ff <= GEAR_N;
            end else if (garm_ff && gcnt_ff != {CNT_W{1'b1}}) begin
                gcnt_ff <= gcnt_ff + CNT_ONE;
            end
            if (gdly_ff == CNT_ONE) begin
                gear_2n_ff <= 1'b1;
                phase_ff   <= 1'b0;
            end
            if (gdly_ff != CNT_ZERO) begin
                gdly_ff <= gdly_ff - CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Maximum power saving.
    logic [CNT_W-1:0]  mcnt_ff;
    logic              mr4_mps_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            mps_st     <= DCGP_MPS_OFF;
            mcnt_ff    <= CNT_ZERO;
            mr4_mps_ff <= 1'b0;
        end else begin
            unique case (mps_st)
                DCGP_MPS_OFF: begin
                    if (exe && is_mrs(cw, MR4_SEL) && cw[MPS_BIT]) begin
                        mr4_mps_ff <= 1'b1;
                        mcnt_ff    <= MPED_N;
                        mps_st     <= DCGP_MPS_ENTRY;
                    end
                end
                DCGP_MPS_ENTRY: begin
                    mcnt_ff <= mcnt_ff - CNT_ONE;
                    if (mcnt_ff == CNT_ONE) begin
                        mps_st <= DCGP_MPS_IN;
                    end
                end
                // CS high at CKE rise stays.
                // CS low at CKE rise exits.
                DCGP_MPS_IN: begin
                    if (cke_rise && cs_q) begin
                        mcnt_ff <= XMP_N;
                        mps_st  <= DCGP_MPS_EXIT;
                    end
                end
                DCGP_MPS_EXIT: begin
                    mcnt_ff <= mcnt_ff - CNT_ONE;
                    if (mcnt_ff == CNT_ONE) begin
                        mr4_mps_ff <= 1'b0;
                        mps_st     <= DCGP_MPS_OFF;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parity mode register, status and error log.
    logic [LOG_W-1:0]  log_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pl_ff     <= PL_OFF;
            status_ff <= 1'b0;
        end else begin
            if (exe && is_mrs(cw, MR5_SEL)) begin
                pl_ff <= cw[PL_HI:0];
                if (!cw[PSTAT_BIT]) begin
                    status_ff <= 1'b0;
                end
            end
            if (err_evt) begin
                status_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            log_ff <= '0;
        end else if (err_evt) begin
            log_ff <= {pin_s2_ff[P_PAR], cw[C_ACT], cw[C_BG0+1], cw[C_BG0], cw[C_BA1],
                       cw[C_BA0], cw[C_A17], cw[C_RAS], cw[C_CAS], cw[C_WE],
                       cw[ADDR_W-1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alert window: one counter times pulse width and precharge-all point.
    // The window is never shorter than the row time, so alert always ends idle.
    logic [CNT_W-1:0]  acnt_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            abusy_ff <= 1'b0;
            acnt_ff  <= CNT_ZERO;
        end else if (err_evt) begin
            abusy_ff <= 1'b1;
            acnt_ff  <= CNT_ZERO;
        end else if (abusy_ff) begin
            acnt_ff <= acnt_ff + CNT_ONE;
            if (acnt_ff == AEND_N) begin
                abusy_ff <= 1'b0;
            end
        end
    end

    assign o_alert_n = ~abusy_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_pre_all <= 1'b0;
        end else begin
            o_pre_all <= abusy_ff && (acnt_ff == TRAS_N);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parity delay pipeline; an error flushes the window before it.
    logic [PIPE_D-1:0] pv_ff;
    logic [CMD_W-1:0]  pw_ff [PIPE_D];
    logic [3:0]        pt_ff [PIPE_D];
    logic [3:0]        lat;
    logic              dly_vld;
    logic [CMD_W-1:0]  dly_word;

    assign lat = pl_clocks(pl_ff);

    for (genvar k = 0; k < PIPE_D; k++) begin : g_pipe
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                pv_ff[k] <= 1'b0;
                pw_ff[k] <= '0;
                pt_ff[k] <= '0;
            end else if (err_evt) begin
                pv_ff[k] <= 1'b0;
            end else if (k == 0) begin
                pv_ff[k] <= exe && (lat != 4'h0);
                pw_ff[k] <= cw;
                pt_ff[k] <= lat;
            end else begin
                pv_ff[k] <= pv_ff[k-1];
                pw_ff[k] <= pw_ff[k-1];
                pt_ff[k] <= pt_ff[k-1];
            end
        end
    end

    // Each command leaves at the tap of the delay in force when it was taken, so a
    // write that turns parity off cannot strand commands still in flight.
    always_comb begin
        dly_vld  = 1'b0;
        dly_word = pw_ff[0];
        for (int k = 0; k < PIPE_D; k++) begin
            if (pv_ff[k] && pt_ff[k] == 4'(k + 1)) begin
                dly_vld  = 1'b1;
                dly_word = pw_ff[k];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_cmd_vld  <= 1'b0;
            o_cmd_word <= '0;
        end else if (dly_vld) begin
            o_cmd_vld  <= !err_evt;
            o_cmd_word <= dly_word;
        end else begin
            o_cmd_vld  <= exe && (lat == 4'h0);
            o_cmd_word <= cw;
        end
    end

    assign o_gear_2n      = gear_2n_ff;
    assign o_mps_active   = (mps_st != DCGP_MPS_OFF);
    assign o_mr4_mps      = mr4_mps_ff;
    assign o_parity_delay = pl_ff;
    assign o_par_status   = status_ff;
    assign o_err_log      = {1'b0, status_ff, pl_ff, 3'h0, log_ff};

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_alert_on_err: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        err_evt |=> !o_alert_n [*2])
        else $error("alert not asserted after parity error");

    a_status_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        err_evt |=> status_ff && !o_alert_n)
        else $error("status not set while alert low");

    a_err_dropped: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        err_evt |=> !o_cmd_vld ##1 !o_cmd_vld)
        else $error("erroneous command was issued");

    a_log_held: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        status_ff && $past(status_ff) |-> $stable(log_ff))
        else $error("error log changed while status set");

    a_no_exec_win: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_alert_n |-> !exe && !o_cmd_vld)
        else $error("command run during alert window");

    a_mps_clear: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        mps_st == DCGP_MPS_EXIT && mcnt_ff == CNT_ONE |=> !mr4_mps_ff && !o_mps_active)
        else $error("power save bit not cleared on exit");

    a_mps_ignore: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_mps_active |=> !o_cmd_vld || $past(o_cmd_vld, 1) || pv_ff != '0)
        else $error("command accepted in power save");

    a_sr_half: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_self_refresh |=> !o_gear_2n)
        else $error("quarter rate kept in self refresh");

    a_cke_exit: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        mps_st == DCGP_MPS_IN && cke_rise && cs_q |=> mps_st == DCGP_MPS_EXIT)
        else $error("exit not started on CKE rise");

    a_unchecked: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (status_ff || pl_ff == PL_OFF) |-> !err_evt)
        else $error("parity checked while disabled");

    a_lat4: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        exe && pl_ff == PL_C4 ##1 (pl_ff == PL_C4 && !err_evt) [*4]
        |=> o_cmd_vld)
        else $error("parity delay of four not applied");
endmodule : dcgp_cmd_front
`default_nettype wire

/* File: dcgp_cmd_front_tb.sv */
// Self-checking bench for the command gear, power-save and parity front end.
`default_nettype none
module dcgp_cmd_front_tb
    import dcgp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ALERT_W = 6;
    localparam int ROW_T   = 4;
    typedef struct {
        logic [CMD_W-1:0] word;
        int               due;
    } dcgp_exp_s;
    dcgp_exp_s        exp_q[$];
    dcgp_exp_s        head;
    int               cyc;
    int               mismatches;
    int               n_tests;
    int               seed;
    bit               mon_on;
    logic             ref_clk;
    logic             rst_n;
    logic             self_ref;
    logic             cs_n;
    logic             cke;
    logic             par;
    logic [CMD_W-1:0] word;
    logic [CMD_W-1:0] w;
    logic             vld;
    logic [CMD_W-1:0] cword;
    logic             gear_2n;
    logic             mps;
    logic             mr4;
    logic [2:0]       pdly;
    logic             pstat;
    logic [31:0]      elog;
    logic [31:0]      log_exp;
    logic             pre_all;
    logic             alert_n;

    dcgp_ctrl_model u_ctl (.i_ref_clk(ref_clk), .o_cs_n(cs_n), .o_cke(cke),
                           .o_word(word), .o_par(par));

    // Short counts keep the alert window and power-save walk to a few cycles.
    dcgp_cmd_front #(.GEAR_CMD_DLY(2), .MPED_CYC(2), .XMP_CYC(3), .ALERT_PW_CYC(ALERT_W),
                     .TRAS_CYC(ROW_T), .USE_A17(1'b1)) dut (
        .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_cke(cke),
        .i_act_n(word[22]), .i_ras_n(word[21]), .i_cas_n(word[20]), .i_we_n(word[19]),
        .i_a17(word[14]), .i_bg(word[18:17]), .i_ba(word[16:15]), .i_addr(word[13:0]),
        .i_par(par), .i_self_refresh(self_ref), .o_cmd_vld(vld), .o_cmd_word(cword),
        .o_gear_2n(gear_2n), .o_mps_active(mps), .o_mr4_mps(mr4),
        .o_parity_delay(pdly), .o_par_status(pstat), .o_err_log(elog),
        .o_pre_all(pre_all), .o_alert_n(alert_n));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string m);
        n_tests++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s: %h vs %h", $time, m, seen, want);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic des(input int n);
        repeat (n) u_ctl.drive(1'b1, 1'b1, '0, 1'b0);
    endtask : des

    // A negative delay leaves the arrival cycle unchecked.
    task automatic send(input logic [CMD_W-1:0] c, input bit bad, input bit take, input int d);
        u_ctl.drive(1'b0, 1'b1, c, bad);
        if (take) exp_q.push_back('{c, (d < 0) ? 0 : cyc + 3 + d});
    endtask : send

    function automatic logic [CMD_W-1:0] mrs(input logic [2:0] mr, input logic [13:0] a);
        return {1'b1, 3'h0, 1'b0, mr, 1'b0, a};
    endfunction : mrs

    // Activate-type words only, so a random word never becomes a mode write.
    function automatic logic [CMD_W-1:0] rnd();
        logic [CMD_W-1:0] r;
        r = CMD_W'($random(seed));
        r[C_ACT] = 1'b0;
        return r;
    endfunction : rnd

    ////////////////////////////////////////////////////////////////////////////
    always #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            wrap_up();
        end
    end

    always @(negedge ref_clk) begin
        if (mon_on && vld === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(1'b1, 1'b0, "unexpected command");
            end else begin
                head = exp_q.pop_front();
                check(cword, head.word, "command word");
                if (head.due != 0) check(cyc, head.due, "command delay");
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 5566;
        ref_clk = 1'b0;
        rst_n = 1'b0;
        self_ref = 1'b0;
        mon_on = 1'b0;
        cyc = 0;
        mismatches = 0;
        n_tests = 0;
        des(3);
        rst_n = 1'b1;
        mon_on = 1'b1;
        des(1);
        check({gear_2n, mps, mr4, pdly, pstat, alert_n}, 8'h01, "reset state");
        check(elog, 32'h0000_0000, "reset log");
        $display("test reset done");
        // Back-to-back half-rate commands; parity is ignored while disabled.
        for (int i = 0; i < 12; i++) send(rnd(), i[0], 1'b1, 0);
        des(8);
        $display("test half_rate done");
        for (int c = 1; c <= 4; c++) begin
            send(mrs(MR5_SEL, 14'h0000), 1'b0, 1'b1, -1);
            des(12);
            send(mrs(MR5_SEL, 14'(c)), 1'b0, 1'b1, -1);
            des(4);
            check(pdly, 32'(c), "delay code");
            send(rnd(), 1'b0, 1'b1, (c == 4) ? 8 : c + 3);
            des(12);
        end
        $display("test parity_delay done");
        w = rnd();
        send(w, 1'b1, 1'b0, 0);
        des(3);
        log_exp = {8'h60, ~(^w), w[C_ACT], w[18:15], w[C_A17], w[C_RAS], w[C_CAS], w[C_WE],
                   w[13:0]};
        for (int i = 0; i <= ALERT_W; i++) begin
            check(alert_n, i == ALERT_W, "alert level");
            check(pre_all, i == ROW_T, "precharge all");
            check(pstat, 1'b1, "error status");
            if (i == 1) send(rnd(), 1'b0, 1'b0, 0);
            else des(1);
        end
        check(elog, log_exp, "error log");
        send(rnd(), 1'b1, 1'b1, 8);
        des(14);
        check(alert_n, 1'b1, "no second alert");
        check(elog, log_exp, "first log kept");
        send(mrs(MR5_SEL, 14'h0004), 1'b0, 1'b1, -1);
        des(6);
        check(pstat, 1'b0, "status cleared");
        send(mrs(MR5_SEL, 14'h0014), 1'b0, 1'b1, -1);
        des(6);
        check(pstat, 1'b0, "status one blocked");
        $display("test parity_error done");
        send(mrs(MR5_SEL, 14'h0000), 1'b0, 1'b1, -1);
        des(12);
        send(mrs(MR3_SEL, 14'h0008), 1'b0, 1'b1, 0);
        des(1);
        send('1, 1'b0, 1'b1, 0);
        des(3);
        check(gear_2n, 1'b0, "half rate at sync");
        des(6);
        check(gear_2n, 1'b1, "quarter rate");
        self_ref = 1'b1;
        des(3);
        check(gear_2n, 1'b0, "self refresh drop");
        self_ref = 1'b0;
        des(6);
        check(gear_2n, 1'b0, "no rearm");
        $display("test gear_down done");
        send(mrs(MR4_SEL, 14'h0002), 1'b0, 1'b1, 0);
        des(8);
        check({mps, mr4}, 2'b11, "power save on");
        send(rnd(), 1'b0, 1'b0, 0);
        des(4);
        repeat (2) u_ctl.drive(1'b1, 1'b0, '0, 1'b0);
        des(4);
        check(mps, 1'b1, "stay on cs high");
        repeat (2) u_ctl.drive(1'b1, 1'b0, '0, 1'b0);
        u_ctl.drive(1'b0, 1'b1, '0, 1'b0);
        des(10);
        check({mps, mr4}, 2'b00, "power save exit");
        send(rnd(), 1'b0, 1'b1, 0);
        des(8);
        check(exp_q.size(), 0, "commands seen");
        $display("test power_save done");
        wrap_up();
    end
endmodule : dcgp_cmd_front_tb
`default_nettype wire

/* File: dcgp_ctrl_model.sv */
// Memory controller model that drives the command pins of the front end.
`default_nettype none
module dcgp_ctrl_model
    import dcgp_pkg::*;
(
    input  wire logic                   i_ref_clk,
    output logic                        o_cs_n,
    output logic                        o_cke,
    output logic [dcgp_pkg::CMD_W-1:0]  o_word,
    output logic                        o_par
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_cs_n = 1'b1;
        o_cke  = 1'b1;
        o_word = '0;
        o_par  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // deselect only.
    // A deselect releases the lines, so they flip instead of holding a value.
    // even parity.
    task automatic drive(input logic cs_n, input logic cke,
                         input logic [CMD_W-1:0] w, input bit bad);
        @(negedge i_ref_clk);
        o_cs_n = cs_n;
        o_cke  = cke;
        o_word = cs_n ? ~o_word : w;
        o_par  = (^o_word) ^ bad;
    endtask : drive
endmodule : dcgp_ctrl_model
`default_nettype wire

/* File: dcgp_pkg.sv */
// Shared constants for the command gear, power-save and parity front end.
`default_nettype none
package dcgp_pkg;
    // Synchronised pin vector layout.
    localparam int PIN_W    = 26;
    localparam int P_CS     = 25;
    localparam int P_CKE    = 24;
    localparam int P_PAR    = 23;
    localparam int P_CMD_HI = 22;
    // Command word: act, ras, cas, we, bg[1:0], ba[1:0], a17, addr[13:0].
    localparam int CMD_W    = 23;
    localparam int C_ACT    = 22;
    localparam int C_RAS    = 21;
    localparam int C_CAS    = 20;
    localparam int C_WE     = 19;
    localparam int C_BG0    = 17;
    localparam int C_BA1    = 16;
    localparam int C_BA0    = 15;
    localparam int C_A17    = 14;
    localparam int ADDR_W   = 14;
    localparam int LOG_W    = 24;
    // Mode register numbers and field positions.
    localparam logic [2:0] MR3_SEL    = 3'h3;
    localparam logic [2:0] MR4_SEL    = 3'h4;
    localparam logic [2:0] MR5_SEL    = 3'h5;
    localparam int         GEAR_BIT   = 3;
    localparam int         MPS_BIT    = 1;
    localparam int         PSTAT_BIT  = 4;
    localparam int         PL_HI      = 2;
    // Parity delay codes and their clock counts.
    localparam logic [2:0] PL_OFF     = 3'h0;
    localparam logic [2:0] PL_C4      = 3'h1;
    localparam logic [2:0] PL_C5      = 3'h2;
    localparam logic [2:0] PL_C6      = 3'h3;
    localparam logic [2:0] PL_C8      = 3'h4;
    localparam logic [3:0] PL_N4      = 4'h4;
    localparam logic [3:0] PL_N5      = 4'h5;
    localparam logic [3:0] PL_N6      = 4'h6;
    localparam logic [3:0] PL_N8      = 4'h8;
    localparam int         PIPE_D     = 8;
    // Clock and default timing counts in clocks.
    localparam int CLK_PERIOD_NS      = 40;
    localparam int CNT_W              = 8;
    localparam int GEAR_CMD_CYC       = 4;
    localparam int MPED_CYC_DEF       = 8;
    localparam int XMP_CYC_DEF        = 16;
    localparam int ALERT_PW_CYC_DEF   = 48;
    localparam int TRAS_CYC_DEF       = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
    localparam logic [CNT_W-1:0] CNT_TWO  = 8'h02;
    // Power-save states.
    typedef enum logic [3:0] {
        DCGP_MPS_OFF   = 4'b0001,
        DCGP_MPS_ENTRY = 4'b0010,
        DCGP_MPS_IN    = 4'b0100,
        DCGP_MPS_EXIT  = 4'b1000
    } dcgp_mps_e;
endpackage : dcgp_pkg
`default_nettype wire
